// file: logic/supply_monitor_consts.vh
/*
 * register indices, field positions, reset values and timing figures of the
 * supply monitor and switchover block.
 * assumes: included by the block only; byte address of a register is 4x its index.
 */
`ifndef SUPPLY_MONITOR_CONSTS_VH
`define SUPPLY_MONITOR_CONSTS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_DELTA_THRESHOLD 8'hF3
`define IDX_PERIPHERAL_CONFIG 8'hF4
`define IDX_SWITCHOVER_CONFIG 8'hF5
`define IDX_POWER_EVENT_FLAG 8'hF8
`define IDX_POWER_EVENT_ENABLE 8'hEC
`define IDX_IRQ_ENABLE_PRIORITY_TWO 8'hA9
`define IDX_MEASURE_START 8'hD8
`define IDX_BATTERY_THRESHOLD 8'hFA
`define IDX_BATTERY_RESULT 8'hDF
`define IDX_DC_SENSE_RESULT 8'hEF
`define IDX_SAG_LEVEL 8'h14
`define IDX_SAG_CYCLE_COUNT 8'h1E

// ****************************************
// field positions
// ****************************************
`define BIT_SWITCHOVER 0
`define BIT_RESTORE 1
`define BIT_DC_SENSE 2
`define BIT_BATTERY 3
`define BIT_SAG 4
`define NUM_EVENTS 5
`define BIT_SUPPLY_SOURCE 6
`define BIT_SWITCHOVER_DISABLE 1
`define BIT_BATTERY_PIN_ENABLE 2
`define BIT_POWER_IRQ_GLOBAL 1
`define SELECT_MAIN_ONLY 2'b00
`define SELECT_DC_AND_MAIN 2'b01

// ****************************************
// reset values and bus answers
// ****************************************
`define RST_BYTE 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ****************************************
// timing figures
// ****************************************
`define CLOCK_HZ 20000000
`define DC_SWITCH_DELAY_MS 30
`define RESTORE_DELAY_MS 130
`define DC_SWITCH_CYCLES (`CLOCK_HZ / 1000 * `DC_SWITCH_DELAY_MS)
`define RESTORE_CYCLES (`CLOCK_HZ / 1000 * `RESTORE_DELAY_MS)
`define MEASURE_PERIOD_CYCLES 1000000

`endif

// file: logic/supply_monitor_switchover.v
/*
 * supply monitor and switchover: picks main supply or battery for the
 * internal supply, applies switch and restore delays, latches power events
 * and merges them into one interrupt; registers over axi4-lite.
 * assumes: comparator levels and the battery pin are asynchronous; adc
 * results and the sag event come from logic on ref_clk_i.
 */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
// What this block does
// - return to main once all enabled causes clear
// - dc cause: need dc and main both good
// - pin cause: also need pin high
// - wait 130 ms before returning to main
// - low dc sense switches after 30 ms
// - interrupt off at reset, needs global enable
// - per-event enables pick interrupt sources
// - flags stay latched, software writes to clear
// - main to battery sets switchover flag
// - battery to main sets restore flag
// - flags set regardless of enables; write 0 clears
// - status bit 6 reads 1 on main supply
// - dc result delta over threshold flags event
// - periodic or software-started dc measurement
// - every battery result sets flag; threshold not compared
// - dc comparator low also sets dc flag
// - sag detector event sets sag flag
// - select 01 adds dc cause, 00 main only
// - pin falling edge switches to battery
// - disable bit keeps supply on main
`include "supply_monitor_consts.vh"

module supply_monitor_switchover #(
  parameter DC_SWITCH_CYCLES = `DC_SWITCH_CYCLES,
  parameter RESTORE_CYCLES = `RESTORE_CYCLES,
  parameter MEASURE_PERIOD = `MEASURE_PERIOD_CYCLES
) (
  input wire ref_clk_i, // block clock, 20 MHz
  input wire rst_n_i, // synchronous reset, active low
  input wire [9:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [9:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire main_supply_ok_i, // main supply above 2.75 V, async
  input wire dc_sense_ok_i, // dc sense input above 1.2 V, async
  input wire battery_control_pin_i, // battery control pin, async
  input wire dc_result_valid_i, // dc sense conversion done, pulse
  input wire [7:0] dc_result_i, // dc sense conversion value
  input wire battery_result_valid_i, // battery conversion done, pulse
  input wire [7:0] battery_result_i, // battery conversion value
  input wire sag_event_i, // sag detector event, pulse
  output reg internal_supply_on_main_o, // 1: main supply, 0: battery
  output reg measure_start_o, // launch one dc sense conversion, pulse
  output reg dc_low_warning_o, // dc sense below 1.2 V
  output reg [7:0] sag_level_o, // sag threshold to the detector
  output reg [7:0] sag_cycle_count_o, // sag line cycles to the detector
  output reg power_monitor_interrupt_o // shared interrupt to the core
);

  // ****************************************
  // state codes
  // ****************************************
  localparam [3:0] ST_MAIN = 4'b0001;
  localparam [3:0] ST_DC_WAIT = 4'b0010;
  localparam [3:0] ST_BATTERY = 4'b0100;
  localparam [3:0] ST_RESTORE = 4'b1000;

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg pin_prev_reg;
  wire main_ok = sync2_reg[0];
  wire dc_ok = sync2_reg[1];
  wire pin_high = sync2_reg[2];
  wire pin_fall = pin_prev_reg & ~pin_high;

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 3'b111;
      sync2_reg <= 3'b111;
      pin_prev_reg <= 1'b1;
      dc_low_warning_o <= 1'b0;
    end else begin
      sync1_reg <= {battery_control_pin_i, dc_sense_ok_i, main_supply_ok_i};
      sync2_reg <= sync1_reg;
      pin_prev_reg <= pin_high;
      dc_low_warning_o <= ~dc_ok;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] delta_threshold_reg;
  reg [7:0] switchover_config_reg;
  reg [`NUM_EVENTS-1:0] power_event_enable_reg;
  reg [`NUM_EVENTS-1:0] power_event_flag_reg;
  reg [`NUM_EVENTS-1:0] power_event_flag_next;
  reg power_irq_global_enable;
  reg [7:0] battery_threshold_reg;
  reg [7:0] battery_result_reg;
  reg [7:0] dc_result_reg;
  reg sw_measure_pending_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [21:0] delay_cnt_reg;
  reg [21:0] delay_cnt_next;
  reg [19:0] period_cnt_reg;

  wire [1:0] switchover_select = switchover_config_reg[1:0];
  wire switch_disable = switchover_config_reg[`BIT_SWITCHOVER_DISABLE];
  wire dc_cause_en = (switchover_select == `SELECT_DC_AND_MAIN);
  wire pin_cause_en = switchover_config_reg[`BIT_BATTERY_PIN_ENABLE];

  // ****************************************
  // axi4-lite slave
  // ****************************************
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_idx_reg;
  reg aw_hi_reg;
  reg [7:0] w_byte_reg;
  reg w_strb_reg;
  wire wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  wire [7:0] rd_idx = s_axi_araddr[9:2];

  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_DELTA_THRESHOLD, `IDX_PERIPHERAL_CONFIG, `IDX_SWITCHOVER_CONFIG,
        `IDX_POWER_EVENT_FLAG, `IDX_POWER_EVENT_ENABLE, `IDX_IRQ_ENABLE_PRIORITY_TWO,
        `IDX_MEASURE_START, `IDX_BATTERY_THRESHOLD, `IDX_BATTERY_RESULT,
        `IDX_DC_SENSE_RESULT, `IDX_SAG_LEVEL, `IDX_SAG_CYCLE_COUNT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  wire wr_ok = wr_fire & ~aw_hi_reg & mapped(aw_idx_reg);
  wire wr_en = wr_ok & w_strb_reg;
  wire wr_flags = wr_en & (aw_idx_reg == `IDX_POWER_EVENT_FLAG);
  wire wr_start = wr_en & (aw_idx_reg == `IDX_MEASURE_START);

  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `RST_BYTE;
    case (rd_idx)
      `IDX_DELTA_THRESHOLD: rd_byte = delta_threshold_reg;
      `IDX_PERIPHERAL_CONFIG: rd_byte = {1'b0, internal_supply_on_main_o, 6'b00_0000};
      `IDX_SWITCHOVER_CONFIG: rd_byte = switchover_config_reg;
      `IDX_POWER_EVENT_FLAG: rd_byte = {3'b000, power_event_flag_reg};
      `IDX_POWER_EVENT_ENABLE: rd_byte = {3'b000, power_event_enable_reg};
      `IDX_IRQ_ENABLE_PRIORITY_TWO: rd_byte = {6'b00_0000, power_irq_global_enable, 1'b0};
      `IDX_BATTERY_THRESHOLD: rd_byte = battery_threshold_reg;
      `IDX_BATTERY_RESULT: rd_byte = battery_result_reg;
      `IDX_DC_SENSE_RESULT: rd_byte = dc_result_reg;
      `IDX_SAG_LEVEL: rd_byte = sag_level_o;
      `IDX_SAG_CYCLE_COUNT: rd_byte = sag_cycle_count_o;
      default: rd_byte = `RST_BYTE;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= `RST_BYTE;
      aw_hi_reg <= 1'b0;
      w_byte_reg <= `RST_BYTE;
      w_strb_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[9:2];
        aw_hi_reg <= |s_axi_awaddr[1:0]; // unaligned byte address is refused
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      delta_threshold_reg <= `RST_BYTE;
      switchover_config_reg <= `RST_BYTE;
      power_event_enable_reg <= {`NUM_EVENTS{1'b0}};
      power_irq_global_enable <= 1'b0;
      battery_threshold_reg <= `RST_BYTE;
      sag_level_o <= `RST_BYTE;
      sag_cycle_count_o <= `RST_BYTE;
    end else if (wr_en) begin
      case (aw_idx_reg)
        `IDX_DELTA_THRESHOLD: delta_threshold_reg <= w_byte_reg;
        `IDX_SWITCHOVER_CONFIG: switchover_config_reg <= w_byte_reg;
        `IDX_POWER_EVENT_ENABLE: power_event_enable_reg <= w_byte_reg[`NUM_EVENTS-1:0];
        `IDX_IRQ_ENABLE_PRIORITY_TWO: power_irq_global_enable <= w_byte_reg[`BIT_POWER_IRQ_GLOBAL];
        `IDX_BATTERY_THRESHOLD: battery_threshold_reg <= w_byte_reg;
        `IDX_SAG_LEVEL: sag_level_o <= w_byte_reg;
        `IDX_SAG_CYCLE_COUNT: sag_cycle_count_o <= w_byte_reg;
        default: ;
      endcase
    end
  end

  // ****************************************
  // supply source state machine
  // ****************************************
  wire go_battery = ~switch_disable & (~main_ok | (pin_cause_en & pin_fall));
  wire restore_ok = switch_disable |
    (main_ok & (~dc_cause_en | dc_ok) & (~pin_cause_en | pin_high));

  always @* begin
    state_next = state_reg;
    delay_cnt_next = delay_cnt_reg + 22'd1;
    case (state_reg)
      ST_MAIN: begin
        delay_cnt_next = 22'd0;
        if (go_battery)
          state_next = ST_BATTERY;
        else if (~switch_disable & dc_cause_en & ~dc_ok)
          state_next = ST_DC_WAIT;
      end
      ST_DC_WAIT: begin
        if (go_battery | (delay_cnt_reg == DC_SWITCH_CYCLES[21:0] - 22'd1))
          state_next = ST_BATTERY;
        else if (switch_disable | ~dc_cause_en | dc_ok)
          state_next = ST_MAIN;
      end
      ST_BATTERY: begin
        delay_cnt_next = 22'd0;
        if (switch_disable)
          state_next = ST_MAIN;
        else if (restore_ok)
          state_next = ST_RESTORE;
      end
      ST_RESTORE: begin
        if (switch_disable)
          state_next = ST_MAIN;
        else if (~restore_ok)
          state_next = ST_BATTERY;
        else if (delay_cnt_reg == RESTORE_CYCLES[21:0] - 22'd1)
          state_next = ST_MAIN;
      end
      default: begin
        state_next = ST_MAIN;
        delay_cnt_next = 22'd0;
      end
    endcase
    if (state_next != state_reg)
      delay_cnt_next = 22'd0;
  end

  wire now_main = (state_reg == ST_MAIN) | (state_reg == ST_DC_WAIT);
  wire next_main = (state_next == ST_MAIN) | (state_next == ST_DC_WAIT);

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_MAIN;
      delay_cnt_reg <= 22'd0;
      internal_supply_on_main_o <= 1'b1;
    end else begin
      state_reg <= state_next;
      delay_cnt_reg <= delay_cnt_next;
      internal_supply_on_main_o <= next_main;
    end
  end

  // ****************************************
  // measurement launch and results
  // ****************************************
  wire period_done = (period_cnt_reg == MEASURE_PERIOD[19:0] - 20'd1);
  wire [7:0] dc_delta = (dc_result_i > dc_result_reg) ?
    (dc_result_i - dc_result_reg) : (dc_result_reg - dc_result_i);

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      period_cnt_reg <= 20'd0;
      measure_start_o <= 1'b0;
      sw_measure_pending_reg <= 1'b0;
      dc_result_reg <= `RST_BYTE;
      battery_result_reg <= `RST_BYTE;
    end else begin
      period_cnt_reg <= period_done ? 20'd0 : period_cnt_reg + 20'd1;
      measure_start_o <= (period_done | wr_start) & ~measure_start_o;
      if (wr_start)
        sw_measure_pending_reg <= 1'b1;
      else if (dc_result_valid_i)
        sw_measure_pending_reg <= 1'b0;
      if (dc_result_valid_i)
        dc_result_reg <= dc_result_i;
      if (battery_result_valid_i)
        battery_result_reg <= battery_result_i;
    end
  end

  // ****************************************
  // event flags and interrupt
  // ****************************************
  wire [`NUM_EVENTS-1:0] event_set;
  assign event_set[`BIT_SWITCHOVER] = now_main & ~next_main;
  assign event_set[`BIT_RESTORE] = ~now_main & next_main;
  assign event_set[`BIT_DC_SENSE] = (dc_result_valid_i &
    ((dc_delta > delta_threshold_reg) | sw_measure_pending_reg)) |
    (~dc_ok & ~dc_low_warning_o);
  assign event_set[`BIT_BATTERY] = battery_result_valid_i;
  assign event_set[`BIT_SAG] = sag_event_i;

  always @* begin
    power_event_flag_next = power_event_flag_reg;
    if (wr_flags)
      power_event_flag_next = power_event_flag_reg & w_byte_reg[`NUM_EVENTS-1:0];
    power_event_flag_next = power_event_flag_next | event_set;
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      power_event_flag_reg <= {`NUM_EVENTS{1'b0}};
      power_monitor_interrupt_o <= 1'b0;
    end else begin
      power_event_flag_reg <= power_event_flag_next;
      power_monitor_interrupt_o <= power_irq_global_enable &
        (|(power_event_flag_next & power_event_enable_reg));
    end
  end

endmodule // supply_monitor_switchover

// file: bench/supply_monitor_properties.sv
/*
 * port assertions for the supply monitor and switchover block.
 * assumes: bound to supply_monitor_switchover; inputs pass two sync flops.
 */
module supply_monitor_properties (
  input wire ref_clk_i, // block clock
  input wire rst_n_i, // sync reset, active low
  input wire s_axi_awvalid, // watched
  input wire s_axi_awready, // watched
  input wire s_axi_wvalid, // watched
  input wire s_axi_wready, // watched
  input wire s_axi_bvalid, // watched
  input wire s_axi_arvalid, // watched
  input wire s_axi_arready, // watched
  input wire s_axi_rvalid, // watched
  input wire main_supply_ok_i, // watched
  input wire dc_sense_ok_i, // watched
  input wire internal_supply_on_main_o, // watched
  input wire measure_start_o, // watched
  input wire dc_low_warning_o, // watched
  input wire power_monitor_interrupt_o // watched
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_dc_low;
    !dc_sense_ok_i [*4];
  endsequence
  sequence s_main_low;
    !main_supply_ok_i [*6];
  endsequence
  sequence s_write_taken;
    (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
  endsequence
  a_reset_state: assert property (
    $rose(rst_n_i) |-> internal_supply_on_main_o && !power_monitor_interrupt_o)
    else $error("wrong supply or interrupt after reset");
  // write fires the cycle after both halves are held, bvalid is seen one edge later
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_resp_cause: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready, 2) || $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("write response without transfer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read response without request");
  a_start_pulse: assert property (measure_start_o |=> !measure_start_o)
    else $error("measure start longer than one cycle");
  a_dc_warning: assert property (s_dc_low |-> dc_low_warning_o)
    else $error("dc low warning missing");
  a_main_low: assert property (s_main_low |-> !internal_supply_on_main_o)
    else $error("no switchover on low main supply");
  a_restore_cause: assert property (
    $rose(internal_supply_on_main_o) |-> $past(main_supply_ok_i, 4))
    else $error("return to main while main supply low");
endmodule // supply_monitor_properties

bind supply_monitor_switchover supply_monitor_properties u_supply_monitor_properties (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .main_supply_ok_i(main_supply_ok_i),
  .dc_sense_ok_i(dc_sense_ok_i), .internal_supply_on_main_o(internal_supply_on_main_o),
  .measure_start_o(measure_start_o), .dc_low_warning_o(dc_low_warning_o),
  .power_monitor_interrupt_o(power_monitor_interrupt_o)
);

// file: bench/adc_partner.sv
/*
 * dc sense converter model: answers each launch with one result pulse.
 * assumes: runs on the block clock; result lines toggle every cycle between pulses.
 */
module adc_partner (
  input wire logic ref_clk_i, // block clock
  input wire logic start_i, // conversion launch pulse
  input wire logic [7:0] level_i, // level to convert
  input wire logic slow_i, // 1: answer late
  output logic valid_o = 1'b0, // result ready pulse
  output logic [7:0] data_o = 8'h00 // result, meaningless between pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -1;
  always @(posedge ref_clk_i) begin
    valid_o <= (cnt == 0);
    data_o <= (cnt == 0) ? level_i : ~data_o;
    cnt <= start_i ? (slow_i ? 9 : 0) : ((cnt >= 0) ? cnt - 1 : -1);
  end
endmodule // adc_partner

// file: bench/supply_monitor_switchover_bench.sv
/*
 * self-checking bench for the supply monitor and switchover block.
 * assumes: short delay parameters; byte address is four times the index.
 */
module supply_monitor_switchover_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DCC = 20;
  localparam int RSC = 50;
  logic ref_clk_i = 0, rst_n_i = 0;
  logic [9:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic main_ok = 1, dc_ok = 1, pin = 1, bat_v = 0, sag = 0, slow = 0;
  logic [7:0] bat_d = 0, dc_lvl = 0, sag_lvl, sag_cnt, dc_d, x;
  logic on_main, mstart, dc_warn, irq, dc_v;
  logic [7:0] rw[4] = '{8'hF3, 8'hFA, 8'h14, 8'h1E};
  logic [7:0] xv[4];
  int num_errors = 0, n_tests = 0, t;
  int m_flags = 0, m_en = 0, m_glob = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  supply_monitor_switchover #(.DC_SWITCH_CYCLES(DCC), .RESTORE_CYCLES(RSC),
    .MEASURE_PERIOD(64)) u_supply_monitor_switchover (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .main_supply_ok_i(main_ok), .dc_sense_ok_i(dc_ok), .battery_control_pin_i(pin),
    .dc_result_valid_i(dc_v), .dc_result_i(dc_d), .battery_result_valid_i(bat_v),
    .battery_result_i(bat_d), .sag_event_i(sag), .internal_supply_on_main_o(on_main),
    .measure_start_o(mstart), .dc_low_warning_o(dc_warn), .sag_level_o(sag_lvl),
    .sag_cycle_count_o(sag_cnt), .power_monitor_interrupt_o(irq));
  adc_partner u_adc_partner (.ref_clk_i(ref_clk_i), .start_i(mstart), .level_i(dc_lvl),
    .slow_i(slow), .valid_o(dc_v), .data_o(dc_d));
  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      $display("MISMATCH %0t %s got %h want %h", $time, msg, seen, exp);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'($urandom), d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge ref_clk_i);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!(bvalid && bready));
    bready <= 0;
    rs = bresp;
  endtask
  task automatic rdr(input logic [7:0] idx);
    @(posedge ref_clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge ref_clk_i);
      if (arvalid && arready) arvalid <= 0;
    end while (!(rvalid && rready));
    rready <= 0;
    rd = rdata;
    rs = rresp;
  endtask
  task automatic chk_flags;
    rdr(8'hF8);
    chk(rd, m_flags, "flags");
    chk(irq, m_glob && (m_flags & m_en) != 0, "interrupt");
  endtask
  task automatic waitm(input logic v, input int n);
    t = 0;
    while (on_main !== v && t < n) begin
      @(posedge ref_clk_i);
      t++;
    end
  endtask
  task automatic poll(input int b);
    t = 0;
    do begin
      rdr(8'hF8);
      t++;
    end while (rd[b] !== 1'b1 && t < 40);
    m_flags |= 1 << b;
    chk_flags();
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    give_verdict();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(72));
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1;
    chk_flags();
    rdr(8'hF4);
    chk(rd, 32'h0000_0040, "source on main");
    foreach (rw[i]) begin
      x = 8'($urandom);
      xv[i] = x;
      wr(rw[i], x);
      rdr(rw[i]);
      chk(rd, {24'h0, x}, "read back");
    end
    chk(sag_lvl, xv[2], "sag level out");
    chk(sag_cnt, xv[3], "sag cycles out");
    wr(8'h00, 8'h01);
    chk(rs, 2'b10, "unmapped write");
    rdr(8'h00);
    chk(rs, 2'b10, "unmapped read");
    main_ok <= 0;
    waitm(0, 10);
    chk(on_main, 0, "main low");
    m_flags = 1;
    chk_flags();
    main_ok <= 1;
    waitm(1, RSC + 20);
    chk(t >= RSC && t < RSC + 20, 1, "restore delay");
    m_flags = 3;
    chk_flags();
    wr(8'hEC, 8'h01);
    m_en = 1;
    chk_flags();
    wr(8'hA9, 8'h02);
    m_glob = 1;
    chk_flags();
    wr(8'hF8, 8'hFE);
    m_flags = 2;
    chk_flags();
    wr(8'hEC, 8'h02);
    m_en = 2;
    chk_flags();
    wr(8'hF8, 8'h00);
    m_flags = 0;
    chk_flags();
    wr(8'hF5, 8'h01);
    dc_ok <= 0;
    waitm(0, DCC + 20);
    chk(t >= DCC && t < DCC + 20, 1, "dc switch delay");
    m_flags = 5;
    chk_flags();
    waitm(1, RSC + 20);
    chk(on_main, 0, "dc low holds battery");
    dc_ok <= 1;
    waitm(1, RSC + 20);
    chk(on_main, 1, "dc restore");
    wr(8'hF5, 8'h04);
    wr(8'hF8, 8'h00);
    m_flags = 0;
    pin <= 0;
    waitm(0, 10);
    chk(on_main, 0, "pin fall");
    waitm(1, RSC + 20);
    chk(on_main, 0, "pin low holds battery");
    wr(8'hF5, 8'h06);
    waitm(1, 10);
    chk(on_main, 1, "switchover disabled");
    pin <= 1;
    wr(8'hF5, 8'h00);
    wr(8'hF3, 8'h10);
    wr(8'hF8, 8'h00);
    slow <= 1;
    wr(8'hD8, 8'h01);
    poll(2);
    wr(8'hF8, 8'h00);
    m_flags = 0;
    dc_lvl <= 8'h20;
    poll(2);
    bat_d <= 8'($urandom);
    bat_v <= 1;
    @(posedge ref_clk_i);
    bat_v <= 0;
    poll(3);
    rdr(8'hDF);
    chk(rd, {24'h0, bat_d}, "battery result");
    sag <= 1;
    @(posedge ref_clk_i);
    sag <= 0;
    poll(4);
    wr(8'hEC, 8'h1F);
    m_en = 31;
    chk_flags();
    give_verdict();
  end
endmodule // supply_monitor_switchover_bench
